/* File: core/pgl_axil_slave.sv */
// AXI4-Lite slave front end that turns bus transfers into register strobes.
`timescale 1ns/100ps
module pgl_axil_slave (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [pgl_pkg::ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [pgl_pkg::DATA_W-1:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [pgl_pkg::ADDR_W-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [pgl_pkg::DATA_W-1:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	output logic wr_en_o,
	output logic [pgl_pkg::ADDR_W-1:0] wr_addr_o,
	output logic [pgl_pkg::DATA_W-1:0] wr_data_o,
	output logic [3:0] wr_strb_o,
	input wire logic wr_ok_i,
	output logic rd_en_o,
	output logic [pgl_pkg::ADDR_W-1:0] rd_addr_o,
	input wire logic [pgl_pkg::DATA_W-1:0] rd_data_i,
	input wire logic rd_ok_i
);
	import pgl_pkg::*;

	logic aw_held;
	logic w_held;
	logic [ADDR_W-1:0] awaddr;
	logic [DATA_W-1:0] wdata;
	logic [3:0] wstrb;
	logic bvalid;
	logic [1:0] bresp;
	logic rvalid;
	logic [DATA_W-1:0] rdata;
	logic [1:0] rresp;
	logic next_aw_held;
	logic next_w_held;
	logic [ADDR_W-1:0] next_awaddr;
	logic [DATA_W-1:0] next_wdata;
	logic [3:0] next_wstrb;
	logic next_bvalid;
	logic [1:0] next_bresp;
	logic next_rvalid;
	logic [DATA_W-1:0] next_rdata;
	logic [1:0] next_rresp;

	// Address and data are caught in either order; the write happens once
	// both are held and the previous response has been taken.
	assign s_axi_awready_o = !aw_held;
	assign s_axi_wready_o = !w_held;
	assign wr_en_o = aw_held && w_held && !bvalid;
	assign wr_addr_o = awaddr;
	assign wr_data_o = wdata;
	assign wr_strb_o = wstrb;
	assign s_axi_arready_o = !rvalid;
	assign rd_en_o = s_axi_arvalid_i && !rvalid;
	assign rd_addr_o = s_axi_araddr_i;

	always_comb begin
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_awaddr = awaddr;
		next_wdata = wdata;
		next_wstrb = wstrb;
		next_bvalid = bvalid;
		next_bresp = bresp;
		next_rvalid = rvalid;
		next_rdata = rdata;
		next_rresp = rresp;
		if (s_axi_awvalid_i && !aw_held) begin
			next_aw_held = 1'b1;
			next_awaddr = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && !w_held) begin
			next_w_held = 1'b1;
			next_wdata = s_axi_wdata_i;
			next_wstrb = s_axi_wstrb_i;
		end
		if (wr_en_o) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = wr_ok_i ? RESP_OKAY : RESP_SLVERR;
		end
		if (bvalid && s_axi_bready_i) begin
			next_bvalid = 1'b0;
		end
		if (rd_en_o) begin
			next_rvalid = 1'b1;
			next_rdata = rd_ok_i ? rd_data_i : '0;
			next_rresp = rd_ok_i ? RESP_OKAY : RESP_SLVERR;
		end
		if (rvalid && s_axi_rready_i) begin
			next_rvalid = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			awaddr <= '0;
			wdata <= '0;
			wstrb <= '0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= RESP_OKAY;
		end else begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			awaddr <= next_awaddr;
			wdata <= next_wdata;
			wstrb <= next_wstrb;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
		end
	end

	assign s_axi_bvalid_o = bvalid;
	assign s_axi_bresp_o = bresp;
	assign s_axi_rvalid_o = rvalid;
	assign s_axi_rdata_o = rdata;
	assign s_axi_rresp_o = rresp;
endmodule

/* File: core/pgl_pin_sync.sv */
// Three-stage synchroniser with agreement filter for the pin inputs.
`timescale 1ns/100ps
module pgl_pin_sync #(
	parameter int WIDTH = pgl_pkg::PIN_N
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] level_o
);
	import pgl_pkg::*;

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;
	logic [WIDTH-1:0] level;
	logic [WIDTH-1:0] next_level;

	if (WIDTH < 1) begin : g_width_check
		$error("pgl_pin_sync needs at least one bit");
	end

	// A bit changes only once the second and third stages agree.
	always_comb begin
		next_level = level;
		for (int i = 0; i < WIDTH; i++) begin
			if (stage2[i] == stage3[i]) begin
				next_level[i] = stage2[i];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
			level <= '0;
		end else begin
			stage1 <= async_i;
			stage2 <= stage1;
			stage3 <= stage2;
			level <= next_level;
		end
	end

	assign level_o = level;
endmodule

/* File: core/pgl_pkg.sv */
// Constants, register map and field layout for the low pin group block.
// Notes on behaviour
// (RULE_01) A pin is general-purpose I/O when its function-select bit is zero.
// (RULE_02) Driver-type bit one drives push-pull, zero drives open-drain.
// (RULE_03) Direction bit one makes the pin an output, zero an input.
// (RULE_04) An output pin carries the value written to its data bit.
// (RULE_05) Reading a data bit returns the sampled pin level.
// (RULE_06) Only input pins may raise a wake or interrupt event.
// (RULE_07) A wake event also needs the pin's own wake enable bit set.
// (RULE_08) Reset protection keeps all four fields when a reset reload occurs.
// (RULE_09) Function select resets to EEPROM image, else OTP, else 0xF.
// (RULE_10) Driver type resets to EEPROM image, else OTP, else 0x0.
// (RULE_11) Direction resets to EEPROM image, else OTP, else 0x0, all inputs.
// (RULE_12) Data resets to EEPROM image, else OTP, else 0x0.
// (RULE_13) An input pin's data bit has no stored default; reads show the pin.
// (RULE_14) USB reset or lite reset reloads every field from the last image.
// (RULE_15) Bits 31:16 read as zero and ignore writes.
package pgl_pkg;
	localparam int PIN_N = 4;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int CFG_W = 16;
	localparam int SYNC_STAGES = 3;

	localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'h00;
	localparam logic [ADDR_W-1:0] WAKE_ADDR = 8'h04;
	localparam logic [ADDR_W-1:0] CFG_ADDR = 8'h18;

	localparam int DATA_LSB = 0;
	localparam int DIR_LSB = 4;
	localparam int DRV_LSB = 8;
	localparam int FUNC_LSB = 12;

	localparam int CTRL_LITE_BIT = 0;
	localparam int CTRL_PROT_BIT = 1;
	localparam int WAKE_EN_LSB = 0;
	localparam int WAKE_POL_LSB = 4;

	localparam logic [PIN_N-1:0] FUNC_FALLBACK = 4'hF;
	localparam logic [PIN_N-1:0] DRV_FALLBACK = 4'h0;
	localparam logic [PIN_N-1:0] DIR_FALLBACK = 4'h0;
	localparam logic [PIN_N-1:0] DATA_FALLBACK = 4'h0;
	localparam logic [CFG_W-1:0] CFG_FALLBACK = 16'hF000;
	localparam logic [PIN_N-1:0] WAKE_RESET = 4'h0;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: core/pgl_top.sv */
// Low pin group configuration register, pin drivers and wake qualification.
`timescale 1ns/100ps
module pgl_top (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [pgl_pkg::ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [pgl_pkg::DATA_W-1:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [pgl_pkg::ADDR_W-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [pgl_pkg::DATA_W-1:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic image_load_i,
	input wire logic eeprom_present_i,
	input wire logic [pgl_pkg::CFG_W-1:0] eeprom_image_i,
	input wire logic otp_programmed_i,
	input wire logic [pgl_pkg::CFG_W-1:0] otp_image_i,
	input wire logic usb_reset_i,
	input wire logic [pgl_pkg::PIN_N-1:0] general_pin_n_i,
	output logic [pgl_pkg::PIN_N-1:0] general_pin_n_o,
	output logic [pgl_pkg::PIN_N-1:0] general_pin_n_oe_o,
	output logic [pgl_pkg::PIN_N-1:0] wake_o
);
	import pgl_pkg::*;

	logic wr_en;
	logic [ADDR_W-1:0] wr_addr;
	logic [DATA_W-1:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_ok;
	logic rd_en;
	logic [ADDR_W-1:0] rd_addr;
	logic [DATA_W-1:0] rd_data;
	logic rd_ok;
	logic [PIN_N-1:0] pin_level;

	logic [PIN_N-1:0] pin_function_select;
	logic [PIN_N-1:0] pin_driver_type;
	logic [PIN_N-1:0] pin_direction;
	logic [PIN_N-1:0] pin_data;
	logic [CFG_W-1:0] image;
	logic reset_protect;
	logic [PIN_N-1:0] wake_enable;
	logic [PIN_N-1:0] wake_polarity;
	logic [PIN_N-1:0] next_pin_function_select;
	logic [PIN_N-1:0] next_pin_driver_type;
	logic [PIN_N-1:0] next_pin_direction;
	logic [PIN_N-1:0] next_pin_data;
	logic [CFG_W-1:0] next_image;
	logic next_reset_protect;
	logic [PIN_N-1:0] next_wake_enable;
	logic [PIN_N-1:0] next_wake_polarity;

	logic [CFG_W-1:0] load_image;
	logic lite_soft_reset;
	logic cfg_wr;
	logic reload;

	pgl_axil_slave u_bus (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.s_axi_awaddr_i(s_axi_awaddr_i),
		.s_axi_awvalid_i(s_axi_awvalid_i),
		.s_axi_awready_o(s_axi_awready_o),
		.s_axi_wdata_i(s_axi_wdata_i),
		.s_axi_wstrb_i(s_axi_wstrb_i),
		.s_axi_wvalid_i(s_axi_wvalid_i),
		.s_axi_wready_o(s_axi_wready_o),
		.s_axi_bresp_o(s_axi_bresp_o),
		.s_axi_bvalid_o(s_axi_bvalid_o),
		.s_axi_bready_i(s_axi_bready_i),
		.s_axi_araddr_i(s_axi_araddr_i),
		.s_axi_arvalid_i(s_axi_arvalid_i),
		.s_axi_arready_o(s_axi_arready_o),
		.s_axi_rdata_o(s_axi_rdata_o),
		.s_axi_rresp_o(s_axi_rresp_o),
		.s_axi_rvalid_o(s_axi_rvalid_o),
		.s_axi_rready_i(s_axi_rready_i),
		.wr_en_o(wr_en),
		.wr_addr_o(wr_addr),
		.wr_data_o(wr_data),
		.wr_strb_o(wr_strb),
		.wr_ok_i(wr_ok),
		.rd_en_o(rd_en),
		.rd_addr_o(rd_addr),
		.rd_data_i(rd_data),
		.rd_ok_i(rd_ok)
	);

	pgl_pin_sync #(
		.WIDTH(PIN_N)
	) u_sync (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.async_i(general_pin_n_i),
		.level_o(pin_level)
	);

	assign wr_ok = (wr_addr == CTRL_ADDR) || (wr_addr == WAKE_ADDR) ||
		(wr_addr == CFG_ADDR);
	assign rd_ok = (rd_addr == CTRL_ADDR) || (rd_addr == WAKE_ADDR) ||
		(rd_addr == CFG_ADDR);

	// Image priority: EEPROM, then OTP, then the fixed fallback values.
	assign load_image = eeprom_present_i ? eeprom_image_i :
		(otp_programmed_i ? otp_image_i : CFG_FALLBACK); // RULE_09
	assign lite_soft_reset = wr_en && (wr_addr == CTRL_ADDR) && wr_strb[0] &&
		wr_data[CTRL_LITE_BIT];
	assign reload = usb_reset_i || lite_soft_reset; // RULE_14
	assign cfg_wr = wr_en && (wr_addr == CFG_ADDR);

	// Input-pin data bits read the synchronised level, upper half reads zero.
	always_comb begin
		rd_data = '0;
		unique case (rd_addr)
			CFG_ADDR: begin
				rd_data = {16'h0000, pin_function_select, pin_driver_type,
					pin_direction, pin_level}; // RULE_05 RULE_13 RULE_15
			end
			CTRL_ADDR: begin
				rd_data[CTRL_PROT_BIT] = reset_protect;
			end
			WAKE_ADDR: begin
				rd_data[WAKE_EN_LSB +: PIN_N] = wake_enable;
				rd_data[WAKE_POL_LSB +: PIN_N] = wake_polarity;
			end
			default: begin
				rd_data = '0;
			end
		endcase
	end

	// A reload or image load later in this process wins over a write while reset_protect is clear.
	always_comb begin
		next_pin_function_select = pin_function_select;
		next_pin_driver_type = pin_driver_type;
		next_pin_direction = pin_direction;
		next_pin_data = pin_data;
		next_image = image;
		next_reset_protect = reset_protect;
		next_wake_enable = wake_enable;
		next_wake_polarity = wake_polarity;
		if (cfg_wr && wr_strb[0]) begin
			next_pin_data = wr_data[DATA_LSB +: PIN_N];
			next_pin_direction = wr_data[DIR_LSB +: PIN_N];
		end
		if (cfg_wr && wr_strb[1]) begin
			next_pin_driver_type = wr_data[DRV_LSB +: PIN_N];
			next_pin_function_select = wr_data[FUNC_LSB +: PIN_N];
		end
		if (wr_en && (wr_addr == CTRL_ADDR) && wr_strb[0]) begin
			next_reset_protect = wr_data[CTRL_PROT_BIT];
		end
		if (wr_en && (wr_addr == WAKE_ADDR) && wr_strb[0]) begin
			next_wake_enable = wr_data[WAKE_EN_LSB +: PIN_N];
			next_wake_polarity = wr_data[WAKE_POL_LSB +: PIN_N];
		end
		if (image_load_i) begin
			next_image = load_image;
		end
		if ((image_load_i || reload) && !reset_protect) begin // RULE_08
			next_pin_data = next_image[DATA_LSB +: PIN_N]; // RULE_12
			next_pin_direction = next_image[DIR_LSB +: PIN_N]; // RULE_11
			next_pin_driver_type = next_image[DRV_LSB +: PIN_N]; // RULE_10
			next_pin_function_select = next_image[FUNC_LSB +: PIN_N];
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			pin_function_select <= FUNC_FALLBACK; // RULE_09
			pin_driver_type <= DRV_FALLBACK; // RULE_10
			pin_direction <= DIR_FALLBACK; // RULE_11
			pin_data <= DATA_FALLBACK; // RULE_12
			image <= CFG_FALLBACK;
			reset_protect <= 1'b0;
			wake_enable <= WAKE_RESET;
			wake_polarity <= WAKE_RESET;
		end else begin
			pin_function_select <= next_pin_function_select;
			pin_driver_type <= next_pin_driver_type;
			pin_direction <= next_pin_direction;
			pin_data <= next_pin_data;
			image <= next_image;
			reset_protect <= next_reset_protect;
			wake_enable <= next_wake_enable;
			wake_polarity <= next_wake_polarity;
		end
	end

	// Pin drivers and wake qualification, registered one cycle after config.
	for (genvar i = 0; i < PIN_N; i++) begin : g_pin
		logic next_out;
		logic next_oe;
		logic next_wake;
		always_comb begin
			next_out = pin_data[i]; // RULE_04
			// Open-drain pins only drive while the data bit is low.
			next_oe = !pin_function_select[i] && pin_direction[i] &&
				(pin_driver_type[i] || !pin_data[i]); // RULE_01 RULE_02 RULE_03
			next_wake = !pin_function_select[i] && !pin_direction[i] &&
				wake_enable[i] &&
				(pin_level[i] == wake_polarity[i]); // RULE_06 RULE_07
		end
		always_ff @(posedge clk_i) begin
			if (sys_rst_i) begin
				general_pin_n_o[i] <= 1'b0;
				general_pin_n_oe_o[i] <= 1'b0;
				wake_o[i] <= 1'b0;
			end else begin
				general_pin_n_o[i] <= next_out;
				general_pin_n_oe_o[i] <= next_oe;
				wake_o[i] <= next_wake;
			end
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	a_func_blocks_drive: assert property ( // RULE_01
		(general_pin_n_oe_o & $past(pin_function_select)) == '0)
		else $error("pin drives while not in general I/O mode");
	a_open_drain_low: assert property ( // RULE_02
		(general_pin_n_oe_o & ~$past(pin_driver_type) & $past(pin_data)) == '0)
		else $error("open-drain pin drives a high level");
	a_oe_needs_output: assert property ( // RULE_03
		(general_pin_n_oe_o & ~$past(pin_direction)) == '0)
		else $error("input pin has its driver enabled");
	a_pin_drives_data: assert property ( // RULE_04
		cfg_wr && wr_strb[0] && !reload && !image_load_i |-> ##2
		general_pin_n_o == $past(wr_data[DATA_LSB +: PIN_N], 2))
		else $error("pin value does not follow written data");
	a_read_pin_level: assert property ( // RULE_05
		rd_en && rd_addr == CFG_ADDR |=>
		s_axi_rdata_o[DATA_LSB +: PIN_N] == $past(pin_level))
		else $error("data read does not show the pin level");
	a_wake_input_only: assert property ( // RULE_06
		(wake_o & $past(pin_direction)) == '0)
		else $error("output pin raised a wake event");
	a_wake_needs_enable: assert property ( // RULE_07
		(wake_o & ~$past(wake_enable)) == '0)
		else $error("wake event without its enable bit");
	a_protect_holds: assert property ( // RULE_08
		reload && reset_protect && !wr_en |=>
		$stable(pin_data) && $stable(pin_direction) &&
		$stable(pin_driver_type) && $stable(pin_function_select))
		else $error("protected fields changed on reload");
	a_fallback_reset: assert property ( // RULE_09
		$past(sys_rst_i) |->
		{pin_function_select, pin_driver_type, pin_direction, pin_data} ==
		CFG_FALLBACK)
		else $error("fields not at fallback after reset");
	a_reload_image: assert property ( // RULE_14
		reload && !reset_protect && !image_load_i |=>
		{pin_function_select, pin_driver_type, pin_direction, pin_data} ==
		$past(image))
		else $error("reload did not restore the stored image");
	a_reserved_zero: assert property ( // RULE_15
		s_axi_rvalid_o |-> s_axi_rdata_o[31:16] == 16'h0000)
		else $error("reserved bits read nonzero");
	a_od_never_high: assert property ( // RULE_02
		(general_pin_n_oe_o & general_pin_n_o &
		~$past(pin_driver_type)) == '0)
		else $error("open-drain pin drives a one");
	a_pin_out_data: assert property ( // RULE_04
		general_pin_n_o == $past(pin_data))
		else $error("pin value differs from data field");
	a_wake_gpio_only: assert property ( // RULE_01 RULE_06
		(wake_o & $past(pin_function_select)) == '0)
		else $error("wake event from a pin not in general I/O mode");
	a_wake_level_match: assert property ( // RULE_07
		(wake_o & ($past(pin_level) ^ $past(wake_polarity))) == '0)
		else $error("wake event at the wrong pin level");
	a_image_store: assert property ( // RULE_14
		image_load_i |=> image == $past(load_image))
		else $error("loaded image not stored");
	a_image_apply: assert property ( // RULE_09 RULE_10 RULE_11 RULE_12
		image_load_i && !reset_protect |=>
		{pin_function_select, pin_driver_type, pin_direction, pin_data} ==
		$past(load_image))
		else $error("loaded image not applied to the fields");
	a_protect_load: assert property ( // RULE_08
		image_load_i && reset_protect && !wr_en |=>
		$stable(pin_data) && $stable(pin_direction) &&
		$stable(pin_driver_type) && $stable(pin_function_select))
		else $error("protected fields changed on image load");

	c_cfg_write: cover property (cfg_wr && wr_strb == 4'hF);
	c_wake_seen: cover property (|wake_o);
	c_lite_reload: cover property (lite_soft_reset && !reset_protect);
	c_protected_usb: cover property (usb_reset_i && reset_protect);
	c_protected_load: cover property (image_load_i && reset_protect);
endmodule

/* File: sim/pgl_board_model.sv */
// Board model: pull-ups on the four pins plus optional external drivers.
`timescale 1ns/100ps
module pgl_board_model (
	input wire logic [3:0] pin_o_i,
	input wire logic [3:0] pin_oe_i,
	input wire logic [3:0] ext_en_i,
	input wire logic [3:0] ext_val_i,
	output logic [3:0] pin_level_o
);
	// A pin that nobody drives rests at its pull-up level.
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			if (pin_oe_i[i]) begin
				pin_level_o[i] = pin_o_i[i];
			end else begin
				pin_level_o[i] = ext_en_i[i] ? ext_val_i[i] : 1'b1;
			end
		end
	end
endmodule

/* File: sim/tb_pin_config_group_low.sv */
// Self-checking bench for the low pin group block.
`timescale 1ns/100ps
module tb_pin_config_group_low;
	import pgl_pkg::*;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0] wstrb = 4'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic img_ld = 1'b0;
	logic ee_pr = 1'b0;
	logic otp_pr = 1'b0;
	logic usb_rst = 1'b0;
	logic [15:0] ee_img = 16'h0000;
	logic [15:0] otp_img = 16'h0000;
	logic [3:0] pin_in, pin_out, pin_oe, wake;
	logic [3:0] ext_en = 4'h0;
	logic [3:0] ext_val = 4'h0;
	logic [3:0] m_func, m_drv, m_dir, m_data, m_wen, m_pol;
	logic [15:0] m_img;
	logic m_prot;
	logic [1:0] resp;
	logic [31:0] rd;
	int n_mismatch = 0;
	int checks = 0;
	integer seed = 32'hd8be_0f55;

	always #4 clk_i = ~clk_i;

	pgl_top dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
		.s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
		.s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready), .image_load_i(img_ld),
		.eeprom_present_i(ee_pr), .eeprom_image_i(ee_img),
		.otp_programmed_i(otp_pr), .otp_image_i(otp_img),
		.usb_reset_i(usb_rst), .general_pin_n_i(pin_in),
		.general_pin_n_o(pin_out), .general_pin_n_oe_o(pin_oe),
		.wake_o(wake));

	pgl_board_model board (.pin_o_i(pin_out), .pin_oe_i(pin_oe),
		.ext_en_i(ext_en), .ext_val_i(ext_val), .pin_level_o(pin_in));

	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic print_verdict();
		$display("mismatches %0d checks %0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [1:0] r);
		logic awr, wr, bv;
		logic [1:0] br;
		bv = 1'b0;
		@(posedge clk_i);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!bv) begin
			@(negedge clk_i);
			awr = awready;
			wr = wready;
			bv = bvalid;
			br = bresp;
			@(posedge clk_i);
			if (awr) awvalid <= 1'b0;
			if (wr) wvalid <= 1'b0;
		end
		bready <= 1'b0;
		r = br;
	endtask

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic rv, arr;
		rv = 1'b0;
		@(posedge clk_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!rv) begin
			@(negedge clk_i);
			arr = arready;
			rv = rvalid;
			d = rdata;
			r = rresp;
			@(posedge clk_i);
			if (arr) arvalid <= 1'b0;
		end
		arvalid <= 1'b0;
		rready <= 1'b0;
	endtask

	function automatic logic [3:0] exp_oe();
		return ~m_func & m_dir & (m_drv | ~m_data);
	endfunction

	function automatic logic [3:0] exp_lvl();
		logic [3:0] oe;
		oe = exp_oe();
		return (oe & m_data) | (~oe & ((ext_en & ext_val) | ~ext_en));
	endfunction

	task automatic check_all();
		repeat (8) @(posedge clk_i);
		@(negedge clk_i);
		check("pin_oe", {28'h0, pin_oe}, {28'h0, exp_oe()});
		check("pin_out", {28'h0, pin_out & pin_oe}, {28'h0, m_data & exp_oe()});
		check("wake", {28'h0, wake}, {28'h0,
			~m_func & ~m_dir & m_wen & ~(exp_lvl() ^ m_pol)});
		axi_read(CFG_ADDR, rd, resp);
		check("cfg_read", rd, {16'h0, m_func, m_drv, m_dir, exp_lvl()});
		check("cfg_rresp", {30'h0, resp}, {30'h0, RESP_OKAY});
	endtask

	task automatic cfg_write(input logic [31:0] v, input logic [3:0] s);
		axi_write(CFG_ADDR, v, s, resp);
		check("cfg_bresp", {30'h0, resp}, {30'h0, RESP_OKAY});
		if (s[0]) {m_dir, m_data} = v[7:0];
		if (s[1]) {m_func, m_drv} = v[15:8];
	endtask

	task automatic pulse(input bit usb);
		@(posedge clk_i);
		if (usb) usb_rst <= 1'b1;
		else img_ld <= 1'b1;
		@(posedge clk_i);
		usb_rst <= 1'b0;
		img_ld <= 1'b0;
		if (!m_prot) {m_func, m_drv, m_dir, m_data} = m_img;
	endtask

	initial begin
		#200000;
		n_mismatch++;
		print_verdict();
	end

	initial begin
		{m_func, m_drv, m_dir, m_data} = CFG_FALLBACK;
		m_img = CFG_FALLBACK;
		m_prot = 1'b0;
		m_wen = 4'h0;
		m_pol = 4'h0;
		repeat (4) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		check_all();
		cfg_write(32'hFFFF_00F5, 4'hF);
		check_all();
		for (int i = 0; i < 16; i++) begin
			cfg_write($random(seed), $random(seed));
			{m_pol, m_wen} = $random(seed);
			axi_write(WAKE_ADDR, {24'h0, m_pol, m_wen}, 4'hF, resp);
			axi_read(WAKE_ADDR, rd, resp);
			check("wake_reg", rd, {24'h0, m_pol, m_wen});
			@(posedge clk_i);
			ext_val <= $random(seed);
			ext_en <= $random(seed) & ~exp_oe();
			check_all();
		end
		for (int k = 0; k < 3; k++) begin
			cfg_write($random(seed), 4'hF);
			@(posedge clk_i);
			ee_pr <= (k == 0);
			otp_pr <= (k < 2);
			ee_img <= $random(seed);
			otp_img <= $random(seed);
			@(posedge clk_i);
			m_img = (k == 0) ? ee_img : ((k == 1) ? otp_img : CFG_FALLBACK);
			pulse(1'b0);
			check_all();
		end
		cfg_write($random(seed), 4'hF);
		pulse(1'b1);
		check_all();
		cfg_write($random(seed), 4'hF);
		axi_write(CTRL_ADDR, 32'h0000_0001, 4'hF, resp);
		{m_func, m_drv, m_dir, m_data} = m_img;
		check_all();
		axi_write(CTRL_ADDR, 32'h0000_0002, 4'hF, resp);
		m_prot = 1'b1;
		axi_read(CTRL_ADDR, rd, resp);
		check("ctrl_reg", rd, 32'h0000_0002);
		cfg_write($random(seed), 4'hF);
		pulse(1'b1);
		check_all();
		axi_write(CTRL_ADDR, 32'h0000_0003, 4'hF, resp);
		check_all();
		@(posedge clk_i);
		ee_pr <= 1'b1;
		ee_img <= $random(seed);
		@(posedge clk_i);
		m_img = ee_img;
		pulse(1'b0);
		check_all();
		axi_write(CTRL_ADDR, 32'h0000_0000, 4'hF, resp);
		m_prot = 1'b0;
		pulse(1'b1);
		check_all();
		axi_write(8'h10, 32'hFFFF_FFFF, 4'hF, resp);
		check("bad_bresp", {30'h0, resp}, {30'h0, RESP_SLVERR});
		axi_read(8'h10, rd, resp);
		check("bad_rresp", {30'h0, resp}, {30'h0, RESP_SLVERR});
		check("bad_rdata", rd, 32'h0000_0000);
		check_all();
		@(posedge clk_i);
		sys_rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		{m_func, m_drv, m_dir, m_data} = CFG_FALLBACK;
		m_img = CFG_FALLBACK;
		m_prot = 1'b0;
		m_wen = 4'h0;
		m_pol = 4'h0;
		check_all();
		axi_read(CTRL_ADDR, rd, resp);
		check("ctrl_reset", rd, 32'h0000_0000);
		print_verdict();
	end
endmodule
